// file: common/pss_pkg.sv
// shared constants for the pipelined synchronous sram port
package pss_pkg;
   localparam int ADDR_W = 18;           // word address width
   localparam int LANES = 4;             // byte lanes per word
   localparam int LANE_W = 9;            // bits per byte lane
   localparam int DATA_W = LANES * LANE_W;
   localparam int PIPE_DEPTH = 2;        // command to data distance
   localparam int BURST_LEN = 4;         // words per burst
   localparam logic [1:0] BURST_LAST = 2'h3;
   localparam logic [1:0] BURST_FIRST = 2'h0;
endpackage : pss_pkg

// file: common/pss_if.sv
// pin level interface between the memory controller and the sram port
`timescale 1ns/100ps
`default_nettype none
interface pss_if
   import pss_pkg::*;
   #(parameter int AW = ADDR_W);
   logic [AW-1:0] address;
   logic advance_or_load_n;
   logic clock_gate_n;
   logic write_n;
   logic [LANES-1:0] byte_write_n_any;
   logic chip_select_n_first;
   logic chip_select_high;
   logic chip_select_n_third;
   logic output_enable_n;
   logic sleep_request;
   logic burst_mode;
   // data bus: each end drives out with an active low output enable
   logic [DATA_W-1:0] dq_from_host;
   logic host_dq_oe_n;
   logic [DATA_W-1:0] dq_from_mem;
   logic mem_dq_oe_n;
   logic [DATA_W-1:0] dq_bus;
   assign dq_bus = !mem_dq_oe_n ? dq_from_mem :
                   !host_dq_oe_n ? dq_from_host : '0;
   modport mem (
      input address, advance_or_load_n, clock_gate_n, write_n,
      input byte_write_n_any, chip_select_n_first, chip_select_high,
      input chip_select_n_third, output_enable_n, sleep_request,
      input burst_mode, dq_bus,
      output dq_from_mem, mem_dq_oe_n
   );
   modport host (
      output address, advance_or_load_n, clock_gate_n, write_n,
      output byte_write_n_any, chip_select_n_first, chip_select_high,
      output chip_select_n_third, output_enable_n, sleep_request,
      output burst_mode, dq_from_host, host_dq_oe_n,
      input dq_bus
   );
endinterface : pss_if
`default_nettype wire

// file: logic/pss_mem.sv
// memory end: pipelined sram with burst counter and byte writes
//
// Contract
// RULE_01: address captured on load, enabled, selected edge
// RULE_02: low address bits seed burst counter
// RULE_03: each nine-bit lane has own write enable
// RULE_04: host drives byte enables every write cycle
// RULE_05: byte enables ignored when write_n high
// RULE_06: write data stored two cycles after command
// RULE_07: host may hold all byte enables low
// RULE_08: clock gate high freezes all state; standby_reg still follows sleep_request on a gated edge
// RULE_09: load write_n sets direction for whole burst
// RULE_10: data moves exactly two cycles after command
// RULE_11: all but oe, sleep, mode are clocked
// RULE_12: deselect on load with any select false
// RULE_13: bus floats two cycles after deselect
// RULE_14: oe high floats data pins immediately
// RULE_15: load while selected starts fresh access
// RULE_16: advance steps counter, ignores address and write_n; write_n high on a write burst advance still zeroes that beat's byte enables
// RULE_17: mode high interleaved, low linear, static
// RULE_18: sleep request enters low-power standby
// RULE_19: burst gives four words from one address
// RULE_20: deselect stops burst, pending transfers finish
// RULE_21: linear adds modulo four, interleave xors count
`timescale 1ns/100ps
`default_nettype none
module pss_mem
   import pss_pkg::*;
   #(parameter int AW = ADDR_W,
     parameter int WORDS = 1024)
   (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // sram pins
   pss_if.mem BUS,
   // user side status
   output logic STANDBY,
   output logic BUSY
   );

   typedef enum logic [1:0] {PSS_IDLE, PSS_READ, PSS_WRITE} pss_op_t;

   logic [DATA_W-1:0] array_mem [WORDS];
   logic [AW-1:0] base_reg;
   logic [1:0] start_reg;
   logic [1:0] count_reg;
   pss_op_t op_reg;
   // two stage pipeline of pending transfers
   pss_op_t p_op_reg [PIPE_DEPTH];
   logic [AW-1:0] p_addr_reg [PIPE_DEPTH];
   logic [LANES-1:0] p_be_reg [PIPE_DEPTH];
   logic [DATA_W-1:0] rdata_reg;
   logic rd_drive_reg;
   logic standby_reg;

   // decode of the sampled control pins
   wire enabled = !BUS.clock_gate_n && !standby_reg; // RULE_08 RULE_18
   wire load = !BUS.advance_or_load_n;
   wire selected = !BUS.chip_select_n_first && BUS.chip_select_high &&
                   !BUS.chip_select_n_third;
   wire do_load = enabled && load && selected; // RULE_01 RULE_15
   wire do_desel = enabled && load && !selected; // RULE_12
   wire do_adv = enabled && !load && op_reg != PSS_IDLE &&
                 count_reg != BURST_LAST; // RULE_16 RULE_19
   wire interleave = BUS.burst_mode; // RULE_17
   wire [1:0] count_next = count_reg + 2'h1;
   // RULE_21
   wire [1:0] low_next = interleave ? (start_reg ^ count_next) :
                         (start_reg + count_next);
   wire [AW-1:0] adv_addr = {base_reg[AW-1:2], low_next};
   wire pss_op_t load_op = BUS.write_n ? PSS_READ : PSS_WRITE;
   // byte enables only count on a write cycle
   wire [LANES-1:0] be_in = BUS.write_n ? '0 : ~BUS.byte_write_n_any;
   wire [AW-1:0] stage_addr = do_load ? BUS.address : adv_addr;
   wire pss_op_t stage_op = do_load ? load_op :
                            do_adv ? op_reg : PSS_IDLE;
   wire [LANES-1:0] stage_be = (stage_op == PSS_WRITE) ?
                               be_in : '0; // RULE_04 RULE_05 RULE_09
   wire [$clog2(WORDS)-1:0] mem_idx = p_addr_reg[1][$clog2(WORDS)-1:0];
   wire [$clog2(WORDS)-1:0] rd_idx = p_addr_reg[0][$clog2(WORDS)-1:0];
   // a read right behind a write to the same word sees the new lanes
   wire fwd_hit = p_op_reg[1] == PSS_WRITE &&
                  p_addr_reg[1] == p_addr_reg[0]; // RULE_10
   wire [DATA_W-1:0] rd_word;

   // sleep is asynchronous to the pins, treated as a plain level here
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         standby_reg <= 1'b0;
      end else begin
         standby_reg <= BUS.sleep_request; // RULE_18
      end
   end

   // address and burst state
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         base_reg <= '0;
         start_reg <= BURST_FIRST;
         count_reg <= BURST_FIRST;
         op_reg <= PSS_IDLE;
      end else if (do_load) begin
         base_reg <= BUS.address; // RULE_01
         start_reg <= BUS.address[1:0]; // RULE_02
         count_reg <= BURST_FIRST;
         op_reg <= load_op; // RULE_09
      end else if (do_desel) begin
         op_reg <= PSS_IDLE; // RULE_20
      end else if (do_adv) begin
         count_reg <= count_next; // RULE_16
      end
   end

   // pending transfer pipeline, frozen while clock gate is high
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         p_op_reg[0] <= PSS_IDLE;
         p_op_reg[1] <= PSS_IDLE;
         p_addr_reg[0] <= '0;
         p_addr_reg[1] <= '0;
         p_be_reg[0] <= '0;
         p_be_reg[1] <= '0;
      end else if (enabled) begin // RULE_08
         p_op_reg[0] <= stage_op; // RULE_10
         p_addr_reg[0] <= stage_addr;
         p_be_reg[0] <= stage_be;
         p_op_reg[1] <= p_op_reg[0]; // RULE_20
         p_addr_reg[1] <= p_addr_reg[0];
         p_be_reg[1] <= p_be_reg[0];
      end
   end

   // array write per lane, data taken two cycles after the command
   always_ff @(posedge SYS_CLK) begin
      if (enabled && p_op_reg[1] == PSS_WRITE) begin
         for (int l = 0; l < LANES; l++) begin
            if (p_be_reg[1][l]) begin // RULE_03 RULE_06 RULE_07
               array_mem[mem_idx][l*LANE_W +: LANE_W] <=
                  BUS.dq_bus[l*LANE_W +: LANE_W];
            end
         end
      end
   end

   // read word per lane, bypassing the write landing this edge
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         assign rd_word[g*LANE_W +: LANE_W] =
            (fwd_hit && p_be_reg[1][g]) ?
            BUS.dq_bus[g*LANE_W +: LANE_W] :
            array_mem[rd_idx][g*LANE_W +: LANE_W];
      end
   endgenerate

   // read data register: launched so it stands in the data cycle
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rdata_reg <= '0;
         rd_drive_reg <= 1'b0;
      end else if (enabled) begin
         rdata_reg <= rd_word;
         rd_drive_reg <= (p_op_reg[0] == PSS_READ); // RULE_10 RULE_13
      end
   end

   // output drive, oe gates combinationally
   assign BUS.dq_from_mem = rdata_reg;
   assign BUS.mem_dq_oe_n = !(rd_drive_reg &&
                              !BUS.output_enable_n); // RULE_14
   assign STANDBY = standby_reg;
   assign BUSY = op_reg != PSS_IDLE || p_op_reg[0] != PSS_IDLE ||
                 p_op_reg[1] != PSS_IDLE;
endmodule : pss_mem
`default_nettype wire

// file: logic/pss_host.sv
// host end: issues load, advance and deselect cycles to the sram
`timescale 1ns/100ps
`default_nettype none
module pss_host
   import pss_pkg::*;
   #(parameter int AW = ADDR_W)
   (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // user command port
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic CMD_WRITE,
   input wire logic CMD_BURST,
   input wire logic [AW-1:0] CMD_ADDR,
   input wire logic [LANES-1:0] CMD_BE,
   input wire logic [DATA_W*BURST_LEN-1:0] CMD_WDATA,
   input wire logic STALL,
   input wire logic SLEEP,
   input wire logic LINEAR,
   // read return
   output logic RD_VALID,
   output logic [DATA_W-1:0] RD_DATA,
   // sram pins
   pss_if.host BUS
   );

   typedef enum logic [1:0] {PSH_IDLE, PSH_BURST} psh_state_t;

   psh_state_t state_reg;
   logic [1:0] beat_reg;
   logic write_reg;
   logic [LANES-1:0] be_reg;
   logic [DATA_W*BURST_LEN-1:0] wdata_reg;
   logic [AW-1:0] addr_reg;
   // per stage: valid, write, write data word
   logic [PIPE_DEPTH-1:0] pv_reg;
   logic [PIPE_DEPTH-1:0] pw_reg;
   logic [DATA_W-1:0] pd_reg [PIPE_DEPTH];
   logic [DATA_W-1:0] rd_data_reg;
   logic rd_valid_reg;

   wire go = !STALL; // RULE_08
   wire take = go && CMD_VALID && state_reg == PSH_IDLE;
   wire adv = go && state_reg == PSH_BURST;
   wire issue = take || adv;
   wire issue_wr = take ? CMD_WRITE : write_reg;
   wire [1:0] issue_beat = take ? 2'h0 : beat_reg + 2'h1;
   // each beat carries its own write word down the pipeline
   wire [DATA_W-1:0] issue_data = take ? CMD_WDATA[DATA_W-1:0] :
                                  wdata_reg[issue_beat*DATA_W +: DATA_W];
   wire wr_phase = pv_reg[1] && pw_reg[1];

   // pin drive: load when taking, advance in a burst, deselect otherwise
   assign CMD_READY = go && state_reg == PSH_IDLE;
   assign BUS.clock_gate_n = STALL;
   // idle cycles are deselects so the memory never advances on its own
   assign BUS.advance_or_load_n = adv;
   assign BUS.address = take ? CMD_ADDR : addr_reg;
   assign BUS.write_n = !issue_wr;
   assign BUS.byte_write_n_any = ~(take ? CMD_BE : be_reg); // RULE_04
   assign BUS.chip_select_n_first = !issue;
   assign BUS.chip_select_high = 1'b1;
   assign BUS.chip_select_n_third = 1'b0;
   assign BUS.output_enable_n = 1'b0; // RULE_14
   assign BUS.sleep_request = SLEEP; // RULE_18
   assign BUS.burst_mode = !LINEAR;
   assign BUS.dq_from_host = pd_reg[1];
   assign BUS.host_dq_oe_n = !wr_phase; // RULE_10
   assign RD_VALID = rd_valid_reg;
   assign RD_DATA = rd_data_reg;

   // command sequencer
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_reg <= PSH_IDLE;
         beat_reg <= 2'h0;
         write_reg <= 1'b0;
         be_reg <= '0;
         addr_reg <= '0;
         wdata_reg <= '0;
      end else if (take) begin
         state_reg <= CMD_BURST ? PSH_BURST : PSH_IDLE;
         beat_reg <= 2'h0;
         write_reg <= CMD_WRITE;
         be_reg <= CMD_BE;
         addr_reg <= CMD_ADDR;
         wdata_reg <= CMD_WDATA;
      end else if (adv) begin
         beat_reg <= issue_beat;
         if (issue_beat == BURST_LAST) begin
            state_reg <= PSH_IDLE;
         end
      end
   end

   // transfer pipeline mirrors the two cycle data delay
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         pv_reg <= '0;
         pw_reg <= '0;
         pd_reg[0] <= '0;
         pd_reg[1] <= '0;
      end else if (go) begin
         pv_reg <= {pv_reg[0], issue};
         pw_reg <= {pw_reg[0], issue_wr};
         pd_reg[0] <= issue_data;
         pd_reg[1] <= pd_reg[0];
      end
   end

   // read capture on the edge that ends the data cycle
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rd_valid_reg <= 1'b0;
         rd_data_reg <= '0;
      end else begin
         rd_valid_reg <= go && pv_reg[1] && !pw_reg[1];
         if (go && pv_reg[1] && !pw_reg[1]) begin
            rd_data_reg <= BUS.dq_bus;
         end
      end
   end
endmodule : pss_host
`default_nettype wire

// file: tb/pss_properties.sv
// pin checks between the host and memory ends of the sram port
`timescale 1ns/100ps
`default_nettype none
module pss_properties
   import pss_pkg::*;
   (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // control pins
   input wire logic advance_or_load_n,
   input wire logic clock_gate_n,
   input wire logic write_n,
   input wire logic chip_select_n_first,
   input wire logic chip_select_high,
   input wire logic chip_select_n_third,
   input wire logic output_enable_n,
   // data bus drivers
   input wire logic host_dq_oe_n,
   input wire logic mem_dq_oe_n,
   input wire logic [DATA_W-1:0] dq_from_mem
   );
   logic sel;
   logic load;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // an enabled load cycle with all selects true
   assign sel = !chip_select_n_first && chip_select_high && !chip_select_n_third;
   assign load = !clock_gate_n && !advance_or_load_n && sel;
   a_read_drives: assert property (
      load && write_n ##1 !clock_gate_n |=> !mem_dq_oe_n || output_enable_n)
      else $error("no read data two cycles after load");
   a_write_drives: assert property (
      load && !write_n ##1 !clock_gate_n |=> !host_dq_oe_n && mem_dq_oe_n)
      else $error("no write data two cycles after load");
   a_oe_gates: assert property (
      !mem_dq_oe_n |-> !output_enable_n)
      else $error("memory drives with output enable high");
   a_one_driver: assert property (
      mem_dq_oe_n || host_dq_oe_n)
      else $error("both ends drive the bus");
   a_gate_freeze: assert property (
      clock_gate_n && !mem_dq_oe_n |=> !mem_dq_oe_n && $stable(dq_from_mem))
      else $error("read data moved on a gated edge");
   a_gate_host_hold: assert property (
      clock_gate_n && !host_dq_oe_n |=> !host_dq_oe_n)
      else $error("write data dropped on a gated edge");
   a_desel_float: assert property (
      !clock_gate_n && !advance_or_load_n && !sel ##1 !clock_gate_n
      |=> mem_dq_oe_n)
      else $error("memory drives after deselect");
   a_reset_quiet: assert property (
      $past(RST) |-> mem_dq_oe_n && host_dq_oe_n)
      else $error("bus driven after reset");
   // main traffic seen
   c_read: cover property (load && write_n);
   c_write: cover property (load && !write_n);
   c_stall: cover property (clock_gate_n && !mem_dq_oe_n);
endmodule : pss_properties
`default_nettype wire

// file: tb/pipelined_sync_sram_port_tb.sv
// bench joining the host and memory ends through the pin interface
`timescale 1ns/100ps
`default_nettype none
module pipelined_sync_sram_port_tb
   import pss_pkg::*;
   ();
   logic clk, rst, cmd_valid, cmd_ready, cmd_write, cmd_burst, stall;
   logic sleep, linear, rd_valid, standby, busy;
   logic [ADDR_W-1:0] cmd_addr;
   logic [LANES-1:0] cmd_be;
   logic [DATA_W*BURST_LEN-1:0] cmd_wdata;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] mdl [int];
   int n_fail;
   int checks;
   pss_if bus_if ();
   pss_mem pss_mem_inst (.SYS_CLK(clk), .RST(rst), .BUS(bus_if.mem),
      .STANDBY(standby), .BUSY(busy));
   pss_host pss_host_inst (.SYS_CLK(clk), .RST(rst), .CMD_VALID(cmd_valid),
      .CMD_READY(cmd_ready), .CMD_WRITE(cmd_write), .CMD_BURST(cmd_burst),
      .CMD_ADDR(cmd_addr), .CMD_BE(cmd_be), .CMD_WDATA(cmd_wdata),
      .STALL(stall), .SLEEP(sleep), .LINEAR(linear), .RD_VALID(rd_valid),
      .RD_DATA(rd_data), .BUS(bus_if.host));
   pss_properties pss_properties_inst (.SYS_CLK(clk), .RST(rst),
      .advance_or_load_n(bus_if.advance_or_load_n),
      .clock_gate_n(bus_if.clock_gate_n), .write_n(bus_if.write_n),
      .chip_select_n_first(bus_if.chip_select_n_first),
      .chip_select_high(bus_if.chip_select_high),
      .chip_select_n_third(bus_if.chip_select_n_third),
      .output_enable_n(bus_if.output_enable_n),
      .host_dq_oe_n(bus_if.host_dq_oe_n), .mem_dq_oe_n(bus_if.mem_dq_oe_n),
      .dq_from_mem(bus_if.dq_from_mem));
   // word address of beat k in the selected burst order
   function automatic logic [ADDR_W-1:0] beat(input logic [ADDR_W-1:0] a,
         input int k);
      beat = a;
      beat[1:0] = linear ? a[1:0] + 2'(k) : a[1:0] ^ 2'(k);
   endfunction : beat
   // compares and counts one value
   task automatic check(input string what, input logic [DATA_W-1:0] seen,
         input logic [DATA_W-1:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // prints counts and verdict, ends the run
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done
   // inputs change one step after the rising edge
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   // bounded wait for a level, a timeout ends the run
   task automatic await(ref logic s, input logic v);
      int i;
      i = 0;
      while (s !== v) begin
         tick();
         i++;
         if (i > 50) begin
            n_fail++;
            $display("Error wait timed out");
            test_done();
         end
      end
   endtask : await
   // presents a command and holds it until the accepting edge
   task automatic issue(input logic w, input logic b,
         input logic [ADDR_W-1:0] a, input logic [LANES-1:0] be,
         input logic [DATA_W*BURST_LEN-1:0] d);
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_burst = b;
      cmd_addr = a;
      cmd_be = be;
      cmd_wdata = d;
      await(cmd_ready, 1'b1);
      tick();
   endtask : issue
   // write leaves valid up so another command may follow at once
   task automatic wr(input logic b, input logic [ADDR_W-1:0] a,
         input logic [LANES-1:0] be, input logic [DATA_W*BURST_LEN-1:0] d);
      issue(1'b1, b, a, be, d);
      for (int k = 0; k < (b ? BURST_LEN : 1); k++) begin
         for (int l = 0; l < LANES; l++) begin
            if (be[l]) begin
               mdl[beat(a, k)][l*LANE_W +: LANE_W] =
                  d[k*DATA_W + l*LANE_W +: LANE_W];
            end
         end
      end
   endtask : wr
   // read, optionally stalling after the first beat returns
   task automatic rd(input logic b, input logic [ADDR_W-1:0] a, input int stl);
      issue(1'b0, b, a, '0, '0);
      cmd_valid = 1'b0;
      for (int k = 0; k < (b ? BURST_LEN : 1); k++) begin
         tick();
         await(rd_valid, 1'b1);
         check("read data", rd_data, mdl[beat(a, k)]);
         if (k == 0 && stl > 0) begin
            stall = 1'b1;
            repeat (stl) tick();
            stall = 1'b0;
         end
      end
   endtask : rd
   // free running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // main sequence
   initial begin
      rst = 1'b1;
      {cmd_valid, cmd_write, cmd_burst, stall, sleep} = '0;
      {cmd_addr, cmd_be, cmd_wdata} = '0;
      linear = 1'b1;
      n_fail = 0;
      checks = 0;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      tick();
      // full word, two lanes rewritten, read straight after
      wr(1'b0, 18'h10, 4'hf, 144'h1_2345_6789);
      wr(1'b0, 18'h10, 4'h5, 144'hf_edcb_a987);
      rd(1'b0, 18'h10, 0);
      $display("test lanes done");
      // linear burst, read word by word and as a burst
      wr(1'b1, 18'h21, 4'hf, {36'h4, 36'h3, 36'h2, 36'h1});
      for (int i = 0; i < 4; i++) begin
         rd(1'b0, 18'h20 + 18'(i), 0);
      end
      rd(1'b1, 18'h22, 0);
      $display("test linear done");
      // interleaved burst, burst read stalled mid way
      linear = 1'b0;
      wr(1'b1, 18'h32, 4'hf, {36'h8, 36'h7, 36'h6, 36'h5});
      for (int i = 0; i < 4; i++) begin
         rd(1'b0, 18'h30 + 18'(i), 0);
      end
      rd(1'b1, 18'h31, 3);
      $display("test interleaved done");
      // standby entry and exit, then traffic resumes
      sleep = 1'b1;
      await(standby, 1'b1);
      check("standby", DATA_W'(standby), DATA_W'(1));
      check("busy", DATA_W'(busy), DATA_W'(0));
      sleep = 1'b0;
      await(standby, 1'b0);
      rd(1'b0, 18'h10, 0);
      $display("test sleep done");
      test_done();
   end
endmodule : pipelined_sync_sram_port_tb
`default_nettype wire
